// *** core/nmc_pkg.sv ***
// shared constants, types and helpers for the control network node messaging block
package nmc_pkg;
  // ---------------------------------------------------------------
  // packet header layout
  // ---------------------------------------------------------------
  localparam int HDR_PRIO     = 15;
  localparam int HDR_DST_HI   = 14;
  localparam int HDR_DST_LO   = 10;
  localparam int HDR_SRC_HI   = 9;
  localparam int HDR_SRC_LO   = 5;
  localparam int HDR_RTR      = 4;
  localparam logic [3:0] LEN_ADDR_ONLY = 4'h4;
  localparam logic [3:0] LEN_WITH_DATA = 4'h8;
  // ---------------------------------------------------------------
  // object address layout
  // ---------------------------------------------------------------
  localparam int ADR_RPRIO    = 31;
  localparam int ADR_TYPE_HI  = 30;
  localparam int ADR_TYPE_LO  = 28;
  localparam int ADR_CLU_HI   = 27;
  localparam int ADR_CLU_LO   = 22;
  localparam int ADR_MOD_HI   = 21;
  localparam int ADR_MOD_LO   = 16;
  localparam int ADR_NODE_HI  = 15;
  localparam int ADR_NODE_LO  = 10;
  localparam logic [5:0] ID_BROADCAST = 6'h3E;
  // message type codes
  localparam logic [2:0] MT_READ   = 3'h0;
  localparam logic [2:0] MT_WRITE  = 3'h1;
  localparam logic [2:0] MT_SIGNAL = 3'h2;
  localparam logic [2:0] MT_DATA   = 3'h3;
  localparam logic [2:0] MT_ACK    = 3'h4;
  localparam logic [2:0] MT_NOT_ACKNOWLEDGE_PACKET   = 3'h5;
  // ---------------------------------------------------------------
  // register map, word offsets on the plain register port
  // ---------------------------------------------------------------
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_LIMITS = 3'h1;
  localparam logic [2:0] REG_TOUT   = 3'h2;
  localparam logic [2:0] REG_FMASK  = 3'h3;
  localparam logic [2:0] REG_FMATCH = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  // control and status fields
  localparam int CTL_EN      = 0;
  localparam int CTL_MASTER  = 1;
  localparam int CTL_GRANT   = 2;
  localparam int CTL_OWN_LO  = 3;
  localparam int CTL_MC_LO   = 8;
  localparam int CTL_CLU_LO  = 13;
  localparam int CTL_MOD_LO  = 19;
  localparam int CTL_WIDTH   = 25;
  localparam int STS_WARN    = 16;
  localparam int STS_BOFF    = 17;
  localparam int STS_BUF_LO  = 18;
  // reset values
  localparam logic [24:0] CTRL_RST   = 25'h0;
  localparam logic [15:0] LIMITS_RST = 16'hFF60;
  localparam logic [23:0] TOUT_RST   = 24'h009C40;
  // completion codes
  localparam logic [1:0] DONE_ACK     = 2'h0;
  localparam logic [1:0] DONE_NOT_ACKNOWLEDGE_PACKET    = 2'h1;
  localparam logic [1:0] DONE_TIMEOUT = 2'h2;
  localparam logic [1:0] DONE_REFUSED = 2'h3;
  // transaction states, gray along idle, load, wait
  typedef enum logic [1:0] {
    NMC_IDLE = 2'b00,
    NMC_LOAD = 2'b01,
    NMC_WAIT = 2'b11
  } nmc_state_type;
  // build a header with the fixed request bit set
  function automatic logic [15:0] nmc_make_hdr(input logic prio, input logic [4:0] dst,
                                               input logic [4:0] src, input logic data);
    nmc_make_hdr = {prio, dst, src, 1'b1, (data ? LEN_WITH_DATA : LEN_ADDR_ONLY)};
  endfunction
  // saturating error counter step
  function automatic logic [7:0] nmc_sat_inc(input logic [7:0] v, input logic inc);
    nmc_sat_inc = (inc && v != 8'hFF) ? v + 8'h01 : v;
  endfunction
endpackage

// *** core/nmc_node.sv ***
// message level engine of one node on the hierarchical control network
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - packets are header, object address, optional data word; ten bytes at most.
// - header names source and destination on the same local segment.
// - address word carries absolute target plus operation type.
// - off-segment targets are sent to the own module controller.
// - only masters, or slaves with the grant bit set, read or write; read and write requests from other slaves are refused.
// - master nodes take all segment traffic and select it by acceptance filter.
// - slave nodes take only packets addressed to their own node id.
// - header priority bit arbitrates the segment, zero is high.
// - arriving high priority packet may overwrite a held low priority one.
// - a correctly interpreted packet is answered with an acknowledge.
// - a bad message is answered with a not-acknowledge packet.
// - sender times each exchange; expiry without answer marks it failed.
// - both buffers full: drop packet unanswered and interrupt the processor.
// - separate receive and transmit error counters.
// - warning and bus-off limits are loaded before counting is evaluated.
// - counter at warning limit sets error flag and interrupts, operation continues.
// - counter at bus-off limit stops the node permanently.
// - missing acknowledges never push the node into bus-off.
// - header bit fields: priority, destination, source, request bit, length.
// - address bit fields: routing priority, type, cluster, module, node, object.
module nmc_node (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        rx_valid_i,
  input  wire logic [15:0] rx_hdr_i,
  input  wire logic [31:0] rx_addr_i,
  input  wire logic [31:0] rx_data_i,
  input  wire logic        rx_err_i,
  output logic             tx_valid_o,
  output logic      [15:0] tx_hdr_o,
  output logic      [31:0] tx_addr_o,
  output logic      [31:0] tx_data_o,
  input  wire logic        tx_ready_i,
  input  wire logic        tx_err_i,
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic        req_prio_i,
  input  wire logic        req_rprio_i,
  input  wire logic [2:0]  req_type_i,
  input  wire logic [27:0] req_obj_i,
  input  wire logic        req_has_data_i,
  input  wire logic [31:0] req_data_i,
  output logic             done_o,
  output logic      [1:0]  done_code_o,
  output logic      [31:0] done_data_o,
  output logic             buf_valid_o,
  output logic      [15:0] buf_hdr_o,
  output logic      [31:0] buf_addr_o,
  output logic      [31:0] buf_data_o,
  output logic             buf_pop_ready_o,
  input  wire logic        buf_pop_i,
  input  wire logic        buf_bad_i,
  output logic             overrun_o,
  output logic             err_warn_o,
  output logic             bus_off_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    nmc_pkg::nmc_state_type st;
    logic                   ov;
    logic [15:0]            ohdr;
    logic [31:0]            oaddr;
    logic [31:0]            odata;
    logic                   rp;
    logic [15:0]            rhdr;
    logic [31:0]            raddr;
    logic [15:0]            qhdr;
    logic [31:0]            qaddr;
    logic [31:0]            qdata;
    logic [23:0]            tmr;
    logic [1:0]             bvld;
    logic [1:0][15:0]       bhdr;
    logic [1:0][31:0]       baddr;
    logic [1:0][31:0]       bdata;
    logic [31:0]            rdata;
    logic [24:0]            ctrl;
    logic [15:0]            lim;
    logic [23:0]            tout;
    logic [31:0]            fmask;
    logic [31:0]            fmatch;
    logic [7:0]             rxc;
    logic [7:0]             txc;
    logic                   warn;
    logic                   boff;
    logic                   dn;
    logic [1:0]             dcode;
    logic [31:0]            ddata;
    logic                   ovr;
  } nmc_regs_type;

  nmc_regs_type r;
  nmc_regs_type next_r;

  // ---------------------------------------------------------------
  // decoded views
  // ---------------------------------------------------------------
  logic       en;
  logic       master;
  logic       grant;
  logic [4:0] own_id;
  logic [4:0] mc_id;
  logic [5:0] own_clu;
  logic [5:0] own_mod;
  logic       live;
  logic       rx_ok;
  logic       for_me;
  logic       is_resp;
  logic       filt_hit;
  logic       accept;
  logic       resp_hit;
  logic       req_fire;
  logic       req_rw;
  logic       pop_fire;
  logic       high_in;
  logic [1:0] bcnt;

  assign en       = r.ctrl[nmc_pkg::CTL_EN];
  assign master   = r.ctrl[nmc_pkg::CTL_MASTER];
  assign grant    = r.ctrl[nmc_pkg::CTL_GRANT];
  assign own_id   = r.ctrl[nmc_pkg::CTL_OWN_LO +: 5];
  assign mc_id    = r.ctrl[nmc_pkg::CTL_MC_LO +: 5];
  assign own_clu  = r.ctrl[nmc_pkg::CTL_CLU_LO +: 6];
  assign own_mod  = r.ctrl[nmc_pkg::CTL_MOD_LO +: 6];
  // no traffic before the limits are in, nor after bus-off
  assign live     = en && !r.boff;
  // malformed packets count as receive errors
  assign rx_ok    = rx_hdr_i[nmc_pkg::HDR_RTR] &&
                    (rx_hdr_i[3:0] == nmc_pkg::LEN_ADDR_ONLY ||
                     rx_hdr_i[3:0] == nmc_pkg::LEN_WITH_DATA);
  assign for_me   = rx_hdr_i[nmc_pkg::HDR_DST_HI:nmc_pkg::HDR_DST_LO] == own_id;
  assign is_resp  = rx_addr_i[nmc_pkg::ADR_TYPE_HI:nmc_pkg::ADR_TYPE_LO] == nmc_pkg::MT_ACK ||
                    rx_addr_i[nmc_pkg::ADR_TYPE_HI:nmc_pkg::ADR_TYPE_LO] == nmc_pkg::MT_NOT_ACKNOWLEDGE_PACKET;
  // broadcast node id always passes the filter
  assign filt_hit = (((rx_addr_i ^ r.fmatch) & r.fmask) == 32'h0) ||
                    rx_addr_i[nmc_pkg::ADR_NODE_HI:nmc_pkg::ADR_NODE_LO] ==
                    nmc_pkg::ID_BROADCAST;
  assign accept   = master ? (for_me || filt_hit) : for_me;
  // an answer closes the exchange only from the node and object we asked
  assign resp_hit = r.st == nmc_pkg::NMC_WAIT && for_me &&
                    rx_hdr_i[nmc_pkg::HDR_SRC_HI:nmc_pkg::HDR_SRC_LO] ==
                    r.qhdr[nmc_pkg::HDR_DST_HI:nmc_pkg::HDR_DST_LO] &&
                    rx_addr_i[27:0] == r.qaddr[27:0];
  assign req_fire = req_valid_i && req_ready_o;
  assign req_rw   = req_type_i == nmc_pkg::MT_READ || req_type_i == nmc_pkg::MT_WRITE;
  assign pop_fire = buf_pop_i && buf_pop_ready_o && r.bvld[0];
  assign high_in  = !rx_hdr_i[nmc_pkg::HDR_PRIO];
  assign bcnt     = {1'b0, r.bvld[0]} + {1'b0, r.bvld[1]};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r     = r;
    next_r.dn  = 1'b0;
    next_r.ovr = 1'b0;
    // register port: writes take effect next edge, reads answer next cycle
    next_r.rdata = 32'h0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        nmc_pkg::REG_CTRL:   next_r.ctrl   = reg_wdata_i[nmc_pkg::CTL_WIDTH-1:0];
        nmc_pkg::REG_LIMITS: next_r.lim    = reg_wdata_i[15:0];
        nmc_pkg::REG_TOUT:   next_r.tout   = reg_wdata_i[23:0];
        nmc_pkg::REG_FMASK:  next_r.fmask  = reg_wdata_i;
        nmc_pkg::REG_FMATCH: next_r.fmatch = reg_wdata_i;
        nmc_pkg::REG_STATUS: begin
          if (reg_wdata_i[nmc_pkg::STS_WARN]) begin
            next_r.warn = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        nmc_pkg::REG_CTRL:   next_r.rdata = {7'h0, r.ctrl};
        nmc_pkg::REG_LIMITS: next_r.rdata = {16'h0, r.lim};
        nmc_pkg::REG_TOUT:   next_r.rdata = {8'h0, r.tout};
        nmc_pkg::REG_FMASK:  next_r.rdata = r.fmask;
        nmc_pkg::REG_FMATCH: next_r.rdata = r.fmatch;
        nmc_pkg::REG_STATUS: next_r.rdata = {12'h0, bcnt, r.boff, r.warn, r.txc, r.rxc};
        default:             next_r.rdata = 32'h0;
      endcase
    end
    // separate counters, saturating rather than wrapping
    next_r.rxc = nmc_sat_inc_rx();
    next_r.txc = nmc_pkg::nmc_sat_inc(r.txc, tx_err_i && live);
    // outgoing slot: a sent packet frees it, replies go before requests
    if (r.ov && tx_ready_i && !r.boff) begin
      next_r.ov = 1'b0;
    end
    if (!next_r.ov && live) begin
      if (r.rp) begin
        next_r.ov    = 1'b1;
        next_r.ohdr  = r.rhdr;
        next_r.oaddr = r.raddr;
        next_r.odata = 32'h0;
        next_r.rp    = 1'b0;
      end else if (r.st == nmc_pkg::NMC_LOAD) begin
        next_r.ov    = 1'b1;
        next_r.ohdr  = r.qhdr;
        next_r.oaddr = r.qaddr;
        next_r.odata = r.qdata;
        next_r.st    = nmc_pkg::NMC_WAIT;
        // a zero count still waits one cycle
        next_r.tmr   = (r.tout == 24'h0) ? 24'h000001 : r.tout;
      end
    end
    // a timed-out exchange is reported, not counted as an error
    if (r.st == nmc_pkg::NMC_WAIT) begin
      if (r.tmr <= 24'h000001) begin
        next_r.st    = nmc_pkg::NMC_IDLE;
        next_r.dn    = 1'b1;
        next_r.dcode = nmc_pkg::DONE_TIMEOUT;
        next_r.ddata = 32'h0;
      end else begin
        next_r.tmr = r.tmr - 24'h000001;
      end
    end
    // new request from the processor
    if (req_fire) begin
      if (!master && !grant && req_rw) begin
        next_r.dn    = 1'b1;
        next_r.dcode = nmc_pkg::DONE_REFUSED;
        next_r.ddata = 32'h0;
      end else begin
        // off-segment targets go via the module controller
        next_r.qhdr  = nmc_pkg::nmc_make_hdr(req_prio_i,
                         (req_obj_i[nmc_pkg::ADR_CLU_HI:nmc_pkg::ADR_CLU_LO] != own_clu ||
                          req_obj_i[nmc_pkg::ADR_MOD_HI:nmc_pkg::ADR_MOD_LO] != own_mod) ?
                         mc_id : req_obj_i[nmc_pkg::ADR_NODE_LO +: 5],
                         own_id, req_has_data_i);
        next_r.qaddr = {req_rprio_i, req_type_i, req_obj_i};
        next_r.qdata = req_has_data_i ? req_data_i : 32'h0;
        next_r.st    = nmc_pkg::NMC_LOAD;
      end
    end
    // processor releases the oldest buffer with its verdict
    if (pop_fire) begin
      next_r.rp    = 1'b1;
      next_r.rhdr  = nmc_pkg::nmc_make_hdr(1'b0,
                       r.bhdr[0][nmc_pkg::HDR_SRC_HI:nmc_pkg::HDR_SRC_LO], own_id, 1'b0);
      next_r.raddr = {1'b0, buf_bad_i ? nmc_pkg::MT_NOT_ACKNOWLEDGE_PACKET : nmc_pkg::MT_ACK,
                      r.baddr[0][27:0]};
      next_r.bvld  = {1'b0, r.bvld[1]};
      next_r.bhdr[0]  = r.bhdr[1];
      next_r.baddr[0] = r.baddr[1];
      next_r.bdata[0] = r.bdata[1];
    end
    // receive side
    if (rx_valid_i && live && rx_ok) begin
      if (is_resp) begin
        if (resp_hit) begin
          next_r.st    = nmc_pkg::NMC_IDLE;
          next_r.dn    = 1'b1;
          next_r.dcode = (rx_addr_i[nmc_pkg::ADR_TYPE_HI:nmc_pkg::ADR_TYPE_LO] ==
                          nmc_pkg::MT_ACK) ? nmc_pkg::DONE_ACK : nmc_pkg::DONE_NOT_ACKNOWLEDGE_PACKET;
          next_r.ddata = (rx_hdr_i[3:0] == nmc_pkg::LEN_WITH_DATA) ? rx_data_i : 32'h0;
        end
      end else if (accept) begin
        if (!next_r.bvld[0]) begin
          next_r.bvld[0]  = 1'b1;
          next_r.bhdr[0]  = rx_hdr_i;
          next_r.baddr[0] = rx_addr_i;
          next_r.bdata[0] = rx_data_i;
        end else if (!next_r.bvld[1]) begin
          next_r.bvld[1]  = 1'b1;
          next_r.bhdr[1]  = rx_hdr_i;
          next_r.baddr[1] = rx_addr_i;
          next_r.bdata[1] = rx_data_i;
        end else if (high_in && r.bhdr[1][nmc_pkg::HDR_PRIO]) begin
          // the held low priority packet is lost without an answer
          next_r.bhdr[1]  = rx_hdr_i;
          next_r.baddr[1] = rx_addr_i;
          next_r.bdata[1] = rx_data_i;
        end else if (high_in && r.bhdr[0][nmc_pkg::HDR_PRIO]) begin
          next_r.bhdr[0]  = rx_hdr_i;
          next_r.baddr[0] = rx_addr_i;
          next_r.bdata[0] = rx_data_i;
        end else begin
          // dropped unanswered; the sender sees its own timeout
          next_r.ovr = 1'b1;
        end
      end
    end
    // limits only judged once the node is enabled
    if (en) begin
      if (next_r.rxc >= r.lim[7:0] || next_r.txc >= r.lim[7:0]) begin
        next_r.warn = 1'b1;
      end
      if (next_r.rxc >= r.lim[15:8] || next_r.txc >= r.lim[15:8]) begin
        next_r.boff = 1'b1;
      end
    end
    // bus-off is left only through reset
    if (r.boff) begin
      next_r.boff = 1'b1;
      next_r.ov   = 1'b0;
      next_r.rp   = 1'b0;
    end
  end

  // receive error step: line errors and malformed packets
  function automatic logic [7:0] nmc_sat_inc_rx();
    nmc_sat_inc_rx = nmc_pkg::nmc_sat_inc(r.rxc,
                       live && (rx_err_i || (rx_valid_i && !rx_ok)));
  endfunction

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r        <= '0;
      r.st     <= nmc_pkg::NMC_IDLE;
      r.ctrl   <= nmc_pkg::CTRL_RST;
      r.lim    <= nmc_pkg::LIMITS_RST;
      r.tout   <= nmc_pkg::TOUT_RST;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o     = r.rdata;
  assign tx_valid_o      = r.ov && !r.boff;
  assign tx_hdr_o        = r.ohdr;
  assign tx_addr_o       = r.oaddr;
  assign tx_data_o       = r.odata;
  assign req_ready_o     = r.st == nmc_pkg::NMC_IDLE && live;
  assign done_o          = r.dn;
  assign done_code_o     = r.dcode;
  assign done_data_o     = r.ddata;
  assign buf_valid_o     = r.bvld[0];
  assign buf_hdr_o       = r.bhdr[0];
  assign buf_addr_o      = r.baddr[0];
  assign buf_data_o      = r.bdata[0];
  // one reply slot: the next pop waits until the reply is queued
  assign buf_pop_ready_o = !r.rp;
  assign overrun_o       = r.ovr;
  assign err_warn_o      = r.warn;
  assign bus_off_o       = r.boff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence slave_rw_req;
    req_fire && !master && !grant && req_rw;
  endsequence
  sequence refused_done;
    done_o && done_code_o == nmc_pkg::DONE_REFUSED && req_ready_o;
  endsequence
  sequence good_pop;
    pop_fire && !buf_bad_i;
  endsequence
  sequence ack_sent;
    tx_valid_o && tx_addr_o[30:28] == nmc_pkg::MT_ACK;
  endsequence

  hdr_format_a: assert property (tx_valid_o |-> tx_hdr_o[nmc_pkg::HDR_RTR] &&
    (tx_hdr_o[3:0] == nmc_pkg::LEN_ADDR_ONLY || tx_hdr_o[3:0] == nmc_pkg::LEN_WITH_DATA))
    else $error("bad header format on transmit");
  slave_refuse_a: assert property (slave_rw_req |=> refused_done)
    else $error("slave read or write not refused");
  ack_reply_a: assert property (good_pop ##0 (live && !r.ov && r.st != nmc_pkg::NMC_LOAD)
    |=> ##1 ack_sent)
    else $error("acknowledge not sent after good pop");
  slave_filter_a: assert property (rx_valid_i && live && rx_ok && !master && !for_me &&
    !buf_pop_i |=> bcnt <= $past(bcnt))
    else $error("slave stored a foreign packet");
  overrun_drop_a: assert property (rx_valid_i && live && rx_ok && !is_resp && accept &&
    r.bvld == 2'b11 && !buf_pop_i && !high_in |=> overrun_o && r.bhdr == $past(r.bhdr))
    else $error("overrun not flagged or buffer changed");
  wait_expire_a: assert property (r.st == nmc_pkg::NMC_WAIT && r.tmr == 24'h000001 &&
    !(rx_valid_i && rx_ok && is_resp && resp_hit) |=>
    done_o && done_code_o == nmc_pkg::DONE_TIMEOUT && r.st == nmc_pkg::NMC_IDLE)
    else $error("timeout not reported");
  timeout_count_a: assert property (done_o && done_code_o == nmc_pkg::DONE_TIMEOUT &&
    !$past(tx_err_i) |-> r.txc == $past(r.txc))
    else $error("timeout counted as transmit error");
  busoff_stay_a: assert property (r.boff |=> r.boff [*3] ##0 (!tx_valid_o && !req_ready_o))
    else $error("bus-off left or traffic seen");
  warn_flag_a: assert property (en && (r.rxc >= r.lim[7:0]) |=> err_warn_o)
    else $error("warning flag not set");
  route_mc_a: assert property (req_fire && (master || grant || !req_rw) &&
    req_obj_i[27:22] != own_clu |=>
    r.qhdr[14:10] == $past(mc_id))
    else $error("off-segment request not sent to controller");
  idle_count_a: assert property (!en |=> r.rxc == $past(r.rxc) && (!r.warn || $past(r.warn)))
    else $error("counting before limits loaded");

endmodule
`default_nettype wire

// *** testbench/nmc_peer.sv ***
// peer node model standing on the far side of the packet link
`timescale 1ns/100ps
`default_nettype none
module nmc_peer (
  input  wire logic        clk_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        tx_valid_i,
  input  wire logic [15:0] tx_hdr_i,
  input  wire logic [31:0] tx_addr_i,
  output logic             tx_ready_o,
  output logic             rx_valid_o,
  output logic      [15:0] rx_hdr_o,
  output logic      [31:0] rx_addr_o,
  output logic      [31:0] rx_data_o
);
  logic [15:0] inj_hdr;
  logic [15:0] seen_hdr;
  logic [31:0] inj_addr;
  logic [31:0] seen_addr;
  logic        inj_go = 1'b0;
  logic [2:0]  wait_q = 3'h0;
  initial {tx_ready_o, rx_valid_o, rx_hdr_o, rx_addr_o, rx_data_o} = '0;
  // bench hands a packet over; it goes out at the next edge
  task send(input logic [15:0] h, input logic [31:0] a);
    inj_hdr <= h;
    inj_addr <= a;
    inj_go <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask
  // ready toggles to stall the node; idle lines flip so stale values never match
  always @(posedge clk_i) begin
    tx_ready_o <= ~tx_ready_o;
    rx_valid_o <= inj_go || wait_q == 3'h1;
    rx_hdr_o <= ~rx_hdr_o;
    rx_addr_o <= ~rx_addr_o;
    rx_data_o <= ~rx_data_o;
    if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
    if (tx_valid_i && tx_ready_o) begin
      seen_hdr <= tx_hdr_i;
      seen_addr <= tx_addr_i;
      // requests are answered three edges later unless mode is 2, replies never
      if (tx_addr_i[30:28] < nmc_pkg::MT_ACK && mode_i != 2'h2) wait_q <= 3'h3;
    end
    if (inj_go) begin
      inj_go <= 1'b0;
      rx_hdr_o <= inj_hdr;
      rx_addr_o <= inj_addr;
    end else if (wait_q == 3'h1) begin
      rx_hdr_o <= {1'b0, seen_hdr[9:5], seen_hdr[14:10], 1'b1, 4'h8};
      rx_addr_o <= {3'b010, mode_i[0], seen_addr[27:0]};
      rx_data_o <= 32'h5A5A_C3C3;
    end
  end
endmodule
`default_nettype wire

// *** testbench/nmc_node_tb_top.sv ***
// self-checking bench for the node messaging engine
`timescale 1ns/100ps
`default_nettype none
module nmc_node_tb_top;
  logic        clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, ovr_seen = 1'b0;
  logic        rx_err_i = 1'b0, tx_err_i = 1'b0, req_valid_i = 1'b0, buf_pop_i = 1'b0;
  logic        buf_bad_i = 1'b0, tx_ready, rx_valid, tx_valid_o, done_o, req_ready_o;
  logic        buf_valid_o, buf_pop_ready_o, overrun_o, err_warn_o, bus_off_o;
  logic [1:0]  mode = 2'h0, done_code_o;
  logic [2:0]  reg_addr_i = 3'h0, req_type_i = 3'h0;
  logic [27:0] req_obj_i = 28'h0;
  logic [15:0] rx_hdr, tx_hdr_o, buf_hdr_o;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rx_addr, rx_data, tx_addr_o, done_data_o;
  logic [31:0] tx_data_o, buf_addr_o;
  int          fail_count = 0, cmp_count = 0, cyc = 0;
  nmc_node dut_u (.clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .rx_valid_i(rx_valid), .rx_hdr_i(rx_hdr), .rx_addr_i(rx_addr), .rx_data_i(rx_data),
    .rx_err_i, .tx_valid_o, .tx_hdr_o, .tx_addr_o, .tx_data_o, .tx_ready_i(tx_ready),
    .tx_err_i, .req_valid_i, .req_ready_o, .req_prio_i(1'b1), .req_rprio_i(1'b0), .req_type_i,
    .req_obj_i, .req_has_data_i(1'b1), .req_data_i(32'h0000_1234), .done_o, .done_code_o,
    .done_data_o, .buf_valid_o, .buf_hdr_o, .buf_addr_o, .buf_data_o(), .buf_pop_ready_o,
    .buf_pop_i, .buf_bad_i, .overrun_o, .err_warn_o, .bus_off_o);
  nmc_peer peer_u (.clk_i, .mode_i(mode), .tx_valid_i(tx_valid_o), .tx_hdr_i(tx_hdr_o),
    .tx_addr_i(tx_addr_o), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_hdr_o(rx_hdr),
    .rx_addr_o(rx_addr), .rx_data_o(rx_data));
  initial forever #12.5 clk_i = ~clk_i;
  // overrun is a one-cycle pulse, caught mid-cycle so the check never races it
  always @(negedge clk_i) if (overrun_o) ovr_seen <= 1'b1;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done;
    end
  end
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task boot;
    nrst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
  endtask
  task wr(input logic [2:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i) reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [2:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i) reg_rd_i <= 1'b0;
    @(negedge clk_i) chk("rdata", e, reg_rdata_o);
    @(posedge clk_i);
  endtask
  // one exchange, waiting a bounded time for its completion code
  task req(input logic [2:0] t, input logic [27:0] o, input logic [1:0] e);
    int n;
    n = 0;
    req_type_i <= t;
    req_obj_i <= o;
    req_valid_i <= 1'b1;
    @(posedge clk_i) req_valid_i <= 1'b0;
    do @(negedge clk_i) n++; while (done_o !== 1'b1 && n < 300);
    chk("code", {30'h0, e}, {30'h0, done_code_o});
    chk("done", 32'h1, {31'h0, done_o});
    if (e == 2'h2) chk("wait", 32'h16, n);
    @(posedge clk_i);
  endtask
  task rx(input logic p, input logic [4:0] d);
    peer_u.send({p, d, 5'h04, 5'h14}, 32'h1000_1005);
    repeat (2) @(posedge clk_i);
  endtask
  task pop(input logic bad);
    buf_bad_i <= bad;
    buf_pop_i <= 1'b1;
    @(posedge clk_i) buf_pop_i <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  task errs(input int r, input int t);
    for (int i = 0; i < 5; i++) begin
      rx_err_i <= i < r;
      tx_err_i <= i < t;
      @(posedge clk_i);
    end
  endtask
  initial begin
    boot;
    chk("ready", 32'h0, {31'h0, req_ready_o});
    rd(3'h1, 32'h0000_FF60);
    rd(3'h2, 32'h0000_9C40);
    rd(3'h7, 32'h0);
    wr(3'h0, 32'h113);
    wr(3'h2, 32'h14);
    req(nmc_pkg::MT_WRITE, 28'h000_1005, 2'h0);
    chk("hdr", {17'h1, 5'h04, 5'h02, 5'h18}, {16'h0, peer_u.seen_hdr});
    chk("addr", 32'h1000_1005, peer_u.seen_addr);
    chk("tdata", 32'h0000_1234, tx_data_o);
    chk("data", 32'h5A5A_C3C3, done_data_o);
    mode <= 2'h1;
    req(nmc_pkg::MT_READ, 28'h000_1005, 2'h1);
    mode <= 2'h2;
    req(nmc_pkg::MT_READ, 28'h000_1005, 2'h2);
    rd(3'h5, 32'h0);
    mode <= 2'h0;
    req(nmc_pkg::MT_WRITE, 28'h040_1005, 2'h0);
    chk("dest", 32'h1, {27'h0, peer_u.seen_hdr[14:10]});
    rx(1'b1, 5'h09);
    chk("taken", 32'h1, {31'h0, buf_valid_o});
    chk("baddr", 32'h1000_1005, buf_addr_o);
    pop(1'b0);
    chk("reply", {17'h0, 5'h04, 5'h02, 5'h14}, {16'h0, peer_u.seen_hdr});
    chk("ack", 32'h4, {29'h0, peer_u.seen_addr[30:28]});
    wr(3'h3, 32'hFFFF_FFFF);
    rx(1'b1, 5'h09);
    chk("fmiss", 32'h0, {31'h0, buf_valid_o});
    peer_u.send({1'b1, 5'h09, 5'h04, 5'h14}, 32'h1000_F805);
    @(posedge clk_i);
    chk("bcast", 32'h1, {31'h0, buf_valid_o});
    pop(1'b0);
    $display("test master done");
    wr(3'h0, 32'h111);
    req(nmc_pkg::MT_WRITE, 28'h000_1005, 2'h3);
    req(nmc_pkg::MT_SIGNAL, 28'h000_1005, 2'h0);
    wr(3'h0, 32'h115);
    req(nmc_pkg::MT_WRITE, 28'h000_1005, 2'h0);
    rx(1'b1, 5'h03);
    chk("filter", 32'h0, {31'h0, buf_valid_o});
    repeat (3) rx(1'b1, 5'h02);
    chk("overrun", 32'h1, {31'h0, ovr_seen});
    ovr_seen <= 1'b0;
    rx(1'b0, 5'h02);
    chk("replace", 32'h0, {31'h0, ovr_seen});
    pop(1'b1);
    chk("not_acknowledge_packet", 32'h5, {29'h0, peer_u.seen_addr[30:28]});
    chk("prio", 32'h0, {31'h0, buf_hdr_o[15]});
    $display("test slave done");
    boot;
    wr(3'h0, 32'h113);
    wr(3'h1, 32'h0402);
    errs(2, 3);
    rd(3'h5, 32'h0001_0302);
    chk("busoff", 32'h0, {31'h0, bus_off_o});
    chk("warn", 32'h1, {31'h0, err_warn_o});
    errs(0, 1);
    rd(3'h5, 32'h0003_0402);
    chk("stopped", 32'h0, {31'h0, req_ready_o});
    chk("boff", 32'h1, {31'h0, bus_off_o});
    $display("test errors done");
    test_done;
  end
endmodule
`default_nettype wire
